// >>> shared/mcp_pkg.sv
// constants shared by both ends of the module control pin link
// assumes a single 25 MHz clock on each end
`default_nettype none
package mcp_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ          = 25;
    localparam int T_SEL_ASSERT_NS  = 2000;
    localparam int T_SEL_DEASSERT_NS = 2000;
    localparam int T_RESET_INIT_NS  = 10000;
    localparam int T_INIT_MS        = 2000;
    localparam int T_MG_TIMEOUT_NS  = 4000;
    localparam int SEL_ASSERT_CYC   = (T_SEL_ASSERT_NS * CLK_MHZ + 999) / 1000;
    localparam int SEL_DEASSERT_CYC = (T_SEL_DEASSERT_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_INIT_CYC   = (T_RESET_INIT_NS * CLK_MHZ + 999) / 1000;
    localparam int INIT_CYC         = T_INIT_MS * CLK_MHZ * 1000;
    localparam int MG_TIMEOUT_CYC   = (T_MG_TIMEOUT_NS * CLK_MHZ) / 1000;

    // ----------------------------------------------------------------
    // module management map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_INIT_STATUS = 8'h02;
    localparam logic [7:0] REG_FLAGS       = 8'h03;
    localparam logic [7:0] REG_POWER_CTRL  = 8'h5D;
    localparam logic [7:0] REG_FLAG_MASK   = 8'h64;
    localparam int NDR_BIT        = 0;
    localparam int FLAG_RESET_DONE = 0;
    localparam int FLAG_FAULT     = 1;
    localparam int PWR_OVERRIDE   = 0;
    localparam int PWR_SET        = 1;
    localparam int PWR_HIGH_CLASS = 2;
    localparam logic [2:0] POWER_CTRL_RST = 3'h0;
    localparam logic [7:0] FLAG_MASK_RST  = 8'h03;

    // ----------------------------------------------------------------
    // host controller map (avalon word index)
    // ----------------------------------------------------------------
    localparam logic [2:0] HA_CTRL       = 3'h0;
    localparam logic [2:0] HA_MGMT       = 3'h1;
    localparam logic [2:0] HA_RESULT     = 3'h2;
    localparam logic [2:0] HA_IRQ_STATUS = 3'h3;
    localparam logic [2:0] HA_IRQ_MASK   = 3'h4;
    localparam logic [2:0] HA_PINS       = 3'h5;
    localparam int CTRL_SEL   = 0;
    localparam int CTRL_RESET = 1;
    localparam int CTRL_LP    = 2;
    localparam int MGMT_WE    = 16;
    localparam int RES_BUSY   = 8;
    localparam int RES_NACK   = 9;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_NACK   = 1;
    localparam int IRQ_INT    = 2;
    localparam int IRQ_PRES   = 3;
    localparam logic [2:0] CTRL_RST     = 3'h4;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    typedef enum logic [1:0] {
        MCP_H_IDLE = 2'b00,
        MCP_H_WAIT = 2'b01,
        MCP_H_REQ  = 2'b10
    } mcp_host_state_t;
endpackage
`default_nettype wire

// >>> shared/mcp_if.sv
// pins and management transfer between host board and module
// assumes both ends share mclk; pull-ups are resolved by the reading end
`timescale 1ns/1ps
`default_nettype none
interface mcp_if;
    // control pins driven by the host
    logic       sel_drv_n;
    logic       sel_oe;
    logic       rst_drv_n;
    logic       rst_oe;
    logic       lp_drv;
    logic       lp_oe;
    // open-drain pins driven by the module
    logic       prs_drv_n;
    logic       prs_oe;
    logic       int_drv_n;
    logic       int_oe;
    // management transfer, stands in for the 2-wire bus
    logic       mg_req;
    logic       mg_we;
    logic [7:0] mg_addr;
    logic [7:0] mg_wdata;
    logic       mg_ack;
    logic [7:0] mg_rdata;

    modport module_mp (
        input  sel_drv_n, sel_oe, rst_drv_n, rst_oe, lp_drv, lp_oe,
        input  mg_req, mg_we, mg_addr, mg_wdata,
        output prs_drv_n, prs_oe, int_drv_n, int_oe, mg_ack, mg_rdata
    );
    modport host_mp (
        output sel_drv_n, sel_oe, rst_drv_n, rst_oe, lp_drv, lp_oe,
        output mg_req, mg_we, mg_addr, mg_wdata,
        input  prs_drv_n, prs_oe, int_drv_n, int_oe, mg_ack, mg_rdata
    );
endinterface
`default_nettype wire

// >>> src/mcp_module_end.sv
// module end: select gating, reset and init timing, power mode, int and presence
// assumes the host end drives the control pins from the same mclk
`timescale 1ns/1ps
`default_nettype none
module mcp_module_end #(
    parameter int INIT_CYC = mcp_pkg::INIT_CYC
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // link
    mcp_if.module_mp  pins,
    // user side
    input  wire logic fault_event,
    output logic      low_power,
    output logic      high_power_class,
    output logic      init_pending
);
    localparam int IW = $clog2(INIT_CYC + 1);
    localparam int LW = $clog2(mcp_pkg::RESET_INIT_CYC + 1);
    localparam logic [IW-1:0] INIT_LAST = IW'(INIT_CYC - 1);
    localparam logic [LW-1:0] LOW_MAX   = LW'(mcp_pkg::RESET_INIT_CYC);

    // ----------------------------------------------------------------
    // pin bias and synchronisers
    // ----------------------------------------------------------------
    wire logic [2:0] pin_lvl;
    assign pin_lvl[0] = pins.sel_oe ? pins.sel_drv_n : 1'b1;
    assign pin_lvl[1] = pins.rst_oe ? pins.rst_drv_n : 1'b1;
    assign pin_lvl[2] = pins.lp_oe  ? pins.lp_drv    : 1'b1;

    logic [2:0] sync_a;
    logic [2:0] sync_b;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 3'h7;
            sync_b <= 3'h7;
        end else begin
            sync_a <= pin_lvl;
            sync_b <= sync_a;
        end
    end
    wire logic selected = ~sync_b[0];
    wire logic rst_lvl  = sync_b[1];
    wire logic lp_lvl   = sync_b[2];

    // ----------------------------------------------------------------
    // reset pulse length and init timer
    // ----------------------------------------------------------------
    logic [LW-1:0] low_cnt;
    logic [IW-1:0] init_cnt;
    logic          init_busy;
    logic          ndr;
    // a short glitch on the reset pin is filtered by requiring the full length
    wire logic     long_low  = (low_cnt == LOW_MAX) && !rst_lvl;
    wire logic     init_done = init_busy && rst_lvl && (init_cnt == INIT_LAST);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= '0;
        end else if (rst_lvl) begin
            low_cnt <= '0;
        end else if (low_cnt != LOW_MAX) begin
            low_cnt <= low_cnt + 1'b1;
        end
    end

    // power-up starts the same timer as a pin reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            init_busy <= 1'b1;
            init_cnt  <= '0;
            ndr       <= 1'b1;
        end else if (long_low) begin
            init_busy <= 1'b1;
            init_cnt  <= '0;
            ndr       <= 1'b1;
        end else if (init_done) begin
            init_busy <= 1'b0;
            ndr       <= 1'b0;
        end else if (init_busy && rst_lvl) begin
            init_cnt <= init_cnt + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // management transfers
    // ----------------------------------------------------------------
    logic       ack_done;
    logic [2:0] pwr;
    logic [7:0] flags;
    logic [7:0] mask;
    logic       ndr_seen;

    wire logic take      = pins.mg_req && !ack_done && selected;
    wire logic wr        = take && pins.mg_we;
    wire logic rd        = take && !pins.mg_we;
    wire logic rd_status = rd && (pins.mg_addr == mcp_pkg::REG_INIT_STATUS);
    wire logic rd_flags  = rd && (pins.mg_addr == mcp_pkg::REG_FLAGS);
    wire logic wr_pwr    = wr && (pins.mg_addr == mcp_pkg::REG_POWER_CTRL);
    wire logic wr_mask   = wr && (pins.mg_addr == mcp_pkg::REG_FLAG_MASK);
    wire logic clr_flags = rd_flags && ndr_seen;

    wire logic [7:0] flag_set;
    assign flag_set = {6'h00, fault_event, init_done};

    logic [7:0] rd_mux;
    always_comb begin
        unique case (pins.mg_addr)
            mcp_pkg::REG_INIT_STATUS: rd_mux = {7'h00, ndr};
            mcp_pkg::REG_FLAGS:       rd_mux = flags;
            mcp_pkg::REG_POWER_CTRL:  rd_mux = {5'h00, pwr};
            mcp_pkg::REG_FLAG_MASK:   rd_mux = mask;
            default:                  rd_mux = 8'h00;
        endcase
    end

    // ack is one cycle; the request must drop before the next one is taken
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_done      <= 1'b0;
            pins.mg_ack   <= 1'b0;
            pins.mg_rdata <= 8'h00;
        end else begin
            pins.mg_ack <= take;
            if (take) begin
                ack_done      <= 1'b1;
                pins.mg_rdata <= rd_mux;
            end else if (!pins.mg_req) begin
                ack_done <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers and flags
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pwr  <= mcp_pkg::POWER_CTRL_RST;
            mask <= mcp_pkg::FLAG_MASK_RST;
        end else if (long_low) begin
            pwr  <= mcp_pkg::POWER_CTRL_RST;
            mask <= mcp_pkg::FLAG_MASK_RST;
        end else begin
            if (wr_pwr) begin
                pwr <= pins.mg_wdata[2:0];
            end
            if (wr_mask) begin
                mask <= pins.mg_wdata;
            end
        end
    end

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags    <= 8'h00;
            ndr_seen <= 1'b0;
        end else if (long_low) begin
            flags    <= 8'h00;
            ndr_seen <= 1'b0;
        end else begin
            flags <= (clr_flags ? 8'h00 : flags) | flag_set;
            if (clr_flags) begin
                ndr_seen <= 1'b0;
            end else if (rd_status && !ndr) begin
                ndr_seen <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // open-drain outputs and power mode
    // ----------------------------------------------------------------
    wire logic int_act = |(flags & mask);
    assign pins.int_drv_n = 1'b0;
    assign pins.int_oe    = int_act;
    assign pins.prs_drv_n = 1'b0;
    assign pins.prs_oe    = 1'b1;

    wire logic next_low_power = lp_lvl
        || (pwr[mcp_pkg::PWR_OVERRIDE] && pwr[mcp_pkg::PWR_SET]);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_power        <= 1'b1;
            high_power_class <= 1'b0;
            init_pending     <= 1'b1;
        end else begin
            low_power        <= next_low_power;
            high_power_class <= !next_low_power && pwr[mcp_pkg::PWR_HIGH_CLASS];
            init_pending     <= init_busy;
        end
    end
endmodule
`default_nettype wire

// >>> src/mcp_host_end.sv
// host end: drives control pins, paces management transfers, reports events
// assumes software on avalon-mm and the module end on the same mclk
`timescale 1ns/1ps
`default_nettype none
module mcp_host_end (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // link
    mcp_if.host_mp           pins,
    // avalon-mm slave
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq
);
    localparam logic [6:0] SEL_ON  = 7'(mcp_pkg::SEL_ASSERT_CYC);
    localparam logic [6:0] SEL_OFF = 7'(mcp_pkg::SEL_DEASSERT_CYC);
    localparam logic [6:0] TMO     = 7'(mcp_pkg::MG_TIMEOUT_CYC);

    // ----------------------------------------------------------------
    // bus slave: one wait cycle, then the access completes
    // ----------------------------------------------------------------
    logic       served;
    wire logic  access = avs_read || avs_write;
    wire logic  hit    = access && served;
    assign avs_waitrequest = access && !served;

    logic [2:0]  ctrl;
    logic [16:0] mgmt;
    logic [7:0]  rdata;
    logic        nack;
    logic [3:0]  irq_st;
    logic [3:0]  irq_mask;
    logic [3:0]  irq_set;
    logic [31:0] rd_mux;
    logic [6:0]  sel_age;
    logic [6:0]  wait_cnt;
    logic        sel_q;
    logic        int_q;
    logic        prs_q;
    mcp_pkg::mcp_host_state_t state;
    mcp_pkg::mcp_host_state_t next_state;
    wire logic  busy      = (state != mcp_pkg::MCP_H_IDLE);
    wire logic  in_req    = (state == mcp_pkg::MCP_H_REQ);
    wire logic  wr_hit    = hit && avs_write;
    wire logic  rd_stat   = hit && avs_read && (avs_address == mcp_pkg::HA_IRQ_STATUS);
    wire logic  start     = wr_hit && (avs_address == mcp_pkg::HA_MGMT) && !busy;
    wire logic  mg_end    = in_req && (pins.mg_ack || (wait_cnt == TMO));
    // released lines read as their pull-up level
    wire logic  sel_lvl   = !ctrl[mcp_pkg::CTRL_SEL];
    wire logic  int_lvl   = pins.int_oe ? pins.int_drv_n : 1'b1;
    wire logic  prs_lvl   = pins.prs_oe ? pins.prs_drv_n : 1'b1;
    wire logic  sel_ready = sel_age >= (sel_lvl ? SEL_OFF : SEL_ON);

    // pins are only ever pulled low; the high level is left to the module's bias
    assign pins.sel_drv_n = 1'b0;
    assign pins.sel_oe    = ctrl[mcp_pkg::CTRL_SEL];
    assign pins.rst_drv_n = 1'b0;
    assign pins.rst_oe    = ctrl[mcp_pkg::CTRL_RESET];
    assign pins.lp_drv    = 1'b0;
    assign pins.lp_oe     = !ctrl[mcp_pkg::CTRL_LP];
    assign pins.mg_req    = in_req;
    assign pins.mg_we     = mgmt[mcp_pkg::MGMT_WE];
    assign pins.mg_addr   = mgmt[15:8];
    assign pins.mg_wdata  = mgmt[7:0];
    assign irq_set[mcp_pkg::IRQ_DONE] = mg_end;
    assign irq_set[mcp_pkg::IRQ_NACK] = mg_end && !pins.mg_ack;
    assign irq_set[mcp_pkg::IRQ_INT]  = int_q && !int_lvl;
    assign irq_set[mcp_pkg::IRQ_PRES] = prs_q != prs_lvl;
    assign irq = |(irq_st & irq_mask);

    always_comb begin
        unique case (state)
            mcp_pkg::MCP_H_IDLE: next_state = start ? mcp_pkg::MCP_H_WAIT : state;
            mcp_pkg::MCP_H_WAIT: next_state = sel_ready ? mcp_pkg::MCP_H_REQ : state;
            mcp_pkg::MCP_H_REQ:  next_state = mg_end ? mcp_pkg::MCP_H_IDLE : state;
            default:             next_state = mcp_pkg::MCP_H_IDLE;
        endcase
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            mcp_pkg::HA_CTRL:       rd_mux[2:0]  = ctrl;
            mcp_pkg::HA_MGMT:       rd_mux[16:0] = mgmt;
            mcp_pkg::HA_RESULT:     rd_mux[9:0]  = {nack, busy, rdata};
            mcp_pkg::HA_IRQ_STATUS: rd_mux[3:0]  = irq_st;
            mcp_pkg::HA_IRQ_MASK:   rd_mux[3:0]  = irq_mask;
            mcp_pkg::HA_PINS:       rd_mux[3:0]  = {prs_lvl, int_lvl, 2'b00};
            default:                rd_mux[0]    = 1'b0;
        endcase
    end

    // a status read clears only the bits it returned, so a new event survives
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            served       <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            ctrl         <= mcp_pkg::CTRL_RST;
            irq_mask     <= mcp_pkg::IRQ_MASK_RST;
            irq_st       <= 4'h0;
        end else begin
            served <= access && !served;
            if (access && !served) begin
                avs_readdata <= rd_mux;
            end
            if (wr_hit && (avs_address == mcp_pkg::HA_CTRL)) begin
                ctrl <= avs_writedata[2:0];
            end
            if (wr_hit && (avs_address == mcp_pkg::HA_IRQ_MASK)) begin
                irq_mask <= avs_writedata[3:0];
            end
            irq_st <= (irq_st & ~(rd_stat ? avs_readdata[3:0] : 4'h0)) | irq_set;
        end
    end

    // a module already seated at reset is reported once as a presence change
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= mcp_pkg::MCP_H_IDLE;
            mgmt     <= 17'h0_0000;
            rdata    <= 8'h00;
            nack     <= 1'b0;
            wait_cnt <= 7'h00;
            sel_age  <= 7'h00;
            sel_q    <= 1'b1;
            int_q    <= 1'b1;
            prs_q    <= 1'b1;
        end else begin
            state    <= next_state;
            wait_cnt <= (in_req && !mg_end) ? wait_cnt + 7'h01 : 7'h00;
            sel_age  <= (sel_lvl != sel_q) ? 7'h00 : sel_age + {6'h00, sel_age != 7'h7F};
            sel_q    <= sel_lvl;
            int_q    <= int_lvl;
            prs_q    <= prs_lvl;
            if (start) begin
                mgmt <= avs_writedata[16:0];
            end
            if (mg_end) begin
                rdata <= pins.mg_rdata;
                nack  <= !pins.mg_ack;
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/mcp_chk.sv
// checker for the control pin link between host end and module end
// assumes both ends run on mclk and the link pins float to their pull-up
`timescale 1ns/1ps
`default_nettype none
module mcp_chk #(
    parameter int INIT_CYC = 40
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link
    input wire logic sel_drv_n,
    input wire logic sel_oe,
    input wire logic rst_drv_n,
    input wire logic rst_oe,
    input wire logic prs_drv_n,
    input wire logic prs_oe,
    input wire logic int_drv_n,
    input wire logic int_oe,
    input wire logic mg_req,
    input wire logic mg_ack
);
    // ------------------------------------------------------------
    // pin levels and ages
    // ------------------------------------------------------------
    localparam int SEL_GAP = mcp_pkg::SEL_DEASSERT_CYC;
    // two cycles of slack: sel_age lags the pin by its own register
    localparam int SEL_SET = mcp_pkg::SEL_ASSERT_CYC - 2;
    logic        sel_lvl;
    logic        rst_lvl;
    logic        int_lvl;
    logic        sel_q;
    logic [7:0]  sel_age;
    logic [15:0] rst_age;
    logic [7:0]  next_sel_age;
    logic [15:0] next_rst_age;
    assign sel_lvl = sel_oe ? sel_drv_n : 1'b1;
    assign rst_lvl = rst_oe ? rst_drv_n : 1'b1;
    assign int_lvl = int_oe ? int_drv_n : 1'b1;
    assign next_sel_age = (sel_lvl != sel_q) ? 8'h00 : sel_age + {7'h00, sel_age != 8'hFF};
    assign next_rst_age = !rst_lvl ? 16'h0000 : rst_age + {15'h0000, rst_age != 16'hFFFF};
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q   <= 1'b1;
            sel_age <= 8'h00;
            rst_age <= 16'h0001;
        end else begin
            sel_q   <= sel_lvl;
            sel_age <= next_sel_age;
            rst_age <= next_rst_age;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_no_ack_desel: assert property (mg_ack |-> !sel_lvl)
        else $error("ack while deselected");
    a_ack_in_time: assert property ($rose(mg_req) && !sel_lvl |-> ##[0:40] mg_ack)
        else $error("selected module did not answer");
    a_desel_gap: assert property (sel_lvl && sel_age < SEL_GAP |-> !mg_req)
        else $error("request inside deselect time");
    a_sel_settle: assert property ($rose(mg_req) && !sel_lvl |-> sel_age >= SEL_SET)
        else $error("request inside select time");
    a_int_open_drain: assert property (int_oe |-> !int_drv_n)
        else $error("interrupt driven high");
    a_prs_grounded: assert property ($past(rst_n) |-> prs_oe && !prs_drv_n)
        else $error("presence not grounded");
    a_init_hold: assert property (rst_age != 0 && rst_age < INIT_CYC |-> int_lvl)
        else $error("completion before init time");
    a_init_done: assert property (rst_age == INIT_CYC + 16 |-> !int_lvl)
        else $error("no completion after init time");
    c_ack: cover property (mg_ack);
    c_reset_pulse: cover property ($rose(rst_lvl));
    c_int_fall: cover property ($fell(int_lvl));
endmodule
`default_nettype wire

// >>> sim/test_module_control_pins.sv
// testbench: host end and module end joined by the link, driven over avalon
// assumes ctrl bits mean select asserted, reset asserted, low-power pin level
`timescale 1ns/1ps
`default_nettype none
module test_module_control_pins;
    localparam int INIT = 300;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        fault_event = 1'b0;
    logic [2:0]  avs_address = 3'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    wire logic [31:0] avs_readdata;
    wire logic   avs_waitrequest;
    wire logic   irq;
    wire logic   low_power;
    wire logic   high_power_class;
    wire logic   init_pending;
    wire logic   int_lvl;
    int          failures = 0;
    int          checks = 0;
    mcp_if link();
    assign int_lvl = link.int_oe ? link.int_drv_n : 1'b1;
    mcp_module_end #(.INIT_CYC(INIT)) mcp_module_end_inst (.mclk(mclk), .rst_n(rst_n),
        .pins(link), .fault_event(fault_event), .low_power(low_power),
        .high_power_class(high_power_class), .init_pending(init_pending));
    mcp_host_end mcp_host_end_inst (.mclk(mclk), .rst_n(rst_n), .pins(link),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));
    mcp_chk #(.INIT_CYC(INIT)) mcp_chk_inst (.mclk(mclk), .rst_n(rst_n),
        .sel_drv_n(link.sel_drv_n), .sel_oe(link.sel_oe), .rst_drv_n(link.rst_drv_n),
        .rst_oe(link.rst_oe), .prs_drv_n(link.prs_drv_n), .prs_oe(link.prs_oe),
        .int_drv_n(link.int_drv_n), .int_oe(link.int_oe), .mg_req(link.mg_req),
        .mg_ack(link.mg_ack));
    always #20 mclk = ~mclk;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input bit ok, input string msg);
        checks++;
        if (!ok) begin
            failures++;
            $display("unexpected at %0t ns: %s", $time, msg);
        end
    endtask
    task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 200);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        check(n < 200, "bus cycle hung");
    endtask
    task automatic mg(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic nack);
        logic [31:0] r;
        int n;
        r = {16'h0000, a, d};
        r[mcp_pkg::MGMT_WE] = w;
        av(1'b1, mcp_pkg::HA_MGMT, r, r);
        n = 0;
        do begin
            av(1'b0, mcp_pkg::HA_RESULT, 32'h0, r);
            n++;
        end while (r[mcp_pkg::RES_BUSY] !== 1'b0 && n < 100);
        q = r[7:0];
        nack = r[mcp_pkg::RES_NACK];
    endtask
    task automatic pins(input logic sel, input logic rst, input logic lp);
        logic [31:0] r;
        logic [31:0] q;
        r = 32'h0;
        r[mcp_pkg::CTRL_SEL] = sel;
        r[mcp_pkg::CTRL_RESET] = rst;
        r[mcp_pkg::CTRL_LP] = lp;
        av(1'b1, mcp_pkg::HA_CTRL, r, q);
    endtask
    task automatic wait_int(input logic lvl, input int lim, input string msg);
        int n;
        n = 0;
        while (int_lvl !== lvl && n < lim) begin
            @(posedge mclk);
            n++;
        end
        check(int_lvl === lvl, msg);
    endtask
    // reads status then flags, which hands the interrupt line back
    task automatic release_int;
        logic [7:0] q;
        logic       nk;
        mg(1'b0, mcp_pkg::REG_INIT_STATUS, 8'h00, q, nk);
        check(q[mcp_pkg::NDR_BIT] === 1'b0, "not-ready still set");
        mg(1'b0, mcp_pkg::REG_FLAGS, 8'h00, q, nk);
        repeat (4) @(posedge mclk);
        check(int_lvl === 1'b1, "interrupt not released");
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_powerup;
        logic [31:0] r;
        av(1'b0, mcp_pkg::HA_CTRL, 32'h0, r);
        check(r[2:0] === mcp_pkg::CTRL_RST, "ctrl reset value");
        pins(1'b1, 1'b0, 1'b1);
        repeat (60) @(posedge mclk);
        wait_int(1'b0, INIT + 40, "no completion after power-up");
        check(link.prs_oe === 1'b1 && link.prs_drv_n === 1'b0, "presence");
        repeat (20) @(posedge mclk);
        check(init_pending === 1'b0, "init still pending");
        av(1'b0, mcp_pkg::HA_PINS, 32'h0, r);
        check(r[mcp_pkg::IRQ_PRES] === 1'b0, "presence level");
        check(r[mcp_pkg::IRQ_INT] === 1'b0, "interrupt level");
        release_int();
    endtask
    task automatic t_power;
        logic [7:0] val [4] = '{8'h00, 8'h00, 8'h03, 8'h05};
        logic [3:0] lpv = 4'b0001;
        logic [3:0] elp = 4'b0101;
        logic [3:0] ehp = 4'b1000;
        logic [7:0] q;
        logic       nk;
        for (int i = 0; i < 4; i++) begin
            pins(1'b1, 1'b0, lpv[i]);
            mg(1'b1, mcp_pkg::REG_POWER_CTRL, val[i], q, nk);
            mg(1'b0, mcp_pkg::REG_POWER_CTRL, 8'h00, q, nk);
            check(q[2:0] === val[i][2:0], "power byte readback");
            repeat (8) @(posedge mclk);
            check(low_power === elp[i], "low power state");
            check(high_power_class === ehp[i], "power class");
        end
    endtask
    task automatic t_reset;
        logic [7:0] q;
        logic       nk;
        pins(1'b1, 1'b1, 1'b0);
        repeat (mcp_pkg::RESET_INIT_CYC + 20) @(posedge mclk);
        check(init_pending === 1'b1, "long pulse did not reset");
        pins(1'b1, 1'b0, 1'b0);
        wait_int(1'b0, INIT + 40, "no completion after reset");
        repeat (20) @(posedge mclk);
        check(init_pending === 1'b0, "init still pending");
        mg(1'b0, mcp_pkg::REG_POWER_CTRL, 8'h00, q, nk);
        check(q[2:0] === mcp_pkg::POWER_CTRL_RST, "setting survived reset");
        release_int();
    endtask
    task automatic t_desel;
        logic [7:0] q;
        logic       nk;
        pins(1'b0, 1'b0, 1'b0);
        repeat (60) @(posedge mclk);
        mg(1'b0, mcp_pkg::REG_INIT_STATUS, 8'h00, q, nk);
        check(nk === 1'b1, "deselected module answered");
        pins(1'b1, 1'b0, 1'b0);
        repeat (60) @(posedge mclk);
        mg(1'b0, mcp_pkg::REG_INIT_STATUS, 8'h00, q, nk);
        check(nk === 1'b0, "selected module silent");
    endtask
    task automatic t_fault;
        logic [31:0] r;
        logic [7:0]  q;
        logic        nk;
        av(1'b0, mcp_pkg::HA_IRQ_MASK, 32'h0, r);
        check(r[3:0] === mcp_pkg::IRQ_MASK_RST, "mask reset value");
        av(1'b0, 3'h7, 32'h0, r);
        av(1'b1, mcp_pkg::HA_IRQ_MASK, 32'h0000000F, r);
        av(1'b0, mcp_pkg::HA_IRQ_STATUS, 32'h0, r);
        @(posedge mclk);
        fault_event <= 1'b1;
        @(posedge mclk);
        fault_event <= 1'b0;
        wait_int(1'b0, 40, "fault not flagged");
        repeat (4) @(posedge mclk);
        check(irq === 1'b1, "host irq not raised");
        av(1'b0, mcp_pkg::HA_IRQ_STATUS, 32'h0, r);
        check(r[mcp_pkg::IRQ_INT] === 1'b1, "interrupt event not seen");
        mg(1'b0, mcp_pkg::REG_FLAGS, 8'h00, q, nk);
        check(q[mcp_pkg::FLAG_FAULT] === 1'b1, "fault flag clear");
        av(1'b0, mcp_pkg::HA_IRQ_STATUS, 32'h0, r);
        av(1'b0, mcp_pkg::HA_IRQ_STATUS, 32'h0, r);
        check(r[3:0] === 4'h0 && irq === 1'b0, "status not cleared by read");
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_powerup();
        t_power();
        t_reset();
        t_desel();
        t_fault();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        give_verdict();
    end
endmodule
`default_nettype wire
